// ===== design/vbtp_core.sv
// VC-11 1+1 bi-directional trail protection: selector, bridge, terminations, APS adaptation
//
// Overview of operation
// - Normal output follows working or protection by fail, degrade and command, fast.
// - Normal input always feeds the working output, forming the bridge.
// - Operation type, restore and hold-off changes take effect only while idle.
// - 1+1 bi-directional: both ends agree through APS; no extra traffic.
// - New fail or degrade acted on only after programmable hold-off, 0-10 s.
// - Revertive return to working only after wait-to-restore fault-free time.
// - Revertive accepts lockout, forced and manual to protection, and clear only.
// - Non-revertive accepts lockout, forced or manual to trail i, exercise, clear.
// - Server fail input marks trail failed, degrade input degraded, both high priority.
// - Protection termination source passes data, clock, frame start unchanged.
// - Termination sink trail fail output equals incoming server fail.
// - Reported server fail set only when fail present and reporting enabled.
// - Adaptation source merges APS channel and payload onto one output stream.
// - APS inserted in first four bits of K4 on protection path only.
// - Adaptation sink recovers payload with clock and frame start.
// - APS taken from K4 bits one to four, persistency filtered, protection only.
//
// Added by the designer: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
module vbtp_core #(
	parameter int TICK_CYCLES = vbtp_pkg::TICK_CYCLES
) (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	output logic irq,
	input wire vbtp_pkg::vbtp_stream_type w_ai_in,
	input wire logic [1:0] w_ai_fail,
	input wire vbtp_pkg::vbtp_stream_type p_ai_in,
	input wire logic [1:0] p_ai_fail,
	input wire vbtp_pkg::vbtp_stream_type n_ci_in,
	output vbtp_pkg::vbtp_stream_type n_ai_out,
	output logic trail_fail_action,
	output logic reported_server_fail,
	output vbtp_pkg::vbtp_stream_type w_ai_out,
	output vbtp_pkg::vbtp_stream_type p_ai_out
);
	vbtp_pkg::vbtp_stream_type w_st;
	vbtp_pkg::vbtp_stream_type p_st;
	vbtp_pkg::vbtp_stream_type n_st;
	logic [1:0] w_fail;
	logic [1:0] p_fail;
	logic p_rise;
	logic p_hit;
	logic [1:0] p_pos;
	logic n_hit;
	logic [1:0] n_pos;

	// Working and protection access points (sink), normal connection point (source)
	vbtp_link_port u_w (
		.ref_clk(ref_clk),
		.reset_n(reset_n),
		.pin_stream(w_ai_in),
		.pin_fail(w_ai_fail),
		.stream(w_st),
		.fail(w_fail),
		.rise(),
		.aps_hit(),
		.aps_pos()
	);
	vbtp_link_port u_p (
		.ref_clk(ref_clk),
		.reset_n(reset_n),
		.pin_stream(p_ai_in),
		.pin_fail(p_ai_fail),
		.stream(p_st),
		.fail(p_fail),
		.rise(p_rise),
		.aps_hit(p_hit),
		.aps_pos(p_pos)
	);
	vbtp_link_port u_n (
		.ref_clk(ref_clk),
		.reset_n(reset_n),
		.pin_stream(n_ci_in),
		.pin_fail(2'h0),
		.stream(n_st),
		.fail(),
		.rise(),
		.aps_hit(n_hit),
		.aps_pos(n_pos)
	);

	// Configuration: pending copies written by software, active copies steer the logic
	logic revert_pend;
	logic revert;
	logic report_en;
	logic [6:0] hold_pend;
	logic [6:0] hold_act;
	logic [12:0] wtr_pend;
	logic [12:0] wtr_act;
	vbtp_pkg::vbtp_ext_type ext;
	vbtp_pkg::vbtp_rest_type rest;
	vbtp_pkg::vbtp_rest_type next_rest;
	vbtp_pkg::vbtp_req_type local_req;
	vbtp_pkg::vbtp_req_type remote;
	vbtp_pkg::vbtp_req_type eff;
	logic sel;
	logic next_sel;
	logic [3:0] aps_tx;

	// 100 ms tick for hold-off, restore and exercise timing
	logic [24:0] tick_cnt;
	logic tick;
	assign tick = tick_cnt == 25'(TICK_CYCLES - 1);
	always_ff @(posedge ref_clk)
	begin
		if (!reset_n || tick)
			tick_cnt <= '0;
		else
			tick_cnt <= tick_cnt + 25'h0000001;
	end

	// Fail and degrade per trail, each held off before it counts
	logic [1:0] sf_raw;
	logic [1:0] sd_raw;
	logic [1:0] held;
	assign sf_raw = {p_fail[vbtp_pkg::FAIL_SF], w_fail[vbtp_pkg::FAIL_SF]};
	assign sd_raw = {p_fail[vbtp_pkg::FAIL_SD], w_fail[vbtp_pkg::FAIL_SD]};
	generate
		for (genvar t = 0; t < 2; t++)
		begin : g_hold
			logic seen;
			logic [6:0] cnt;
			// Counting restarts only when the condition first appears, not on toggles of SF/SD
			always_ff @(posedge ref_clk)
			begin
				if (!reset_n)
				begin
					seen <= 1'b0;
					cnt <= '0;
				end
				else if (!(sf_raw[t] | sd_raw[t]))
					seen <= 1'b0;
				else if (!seen)
				begin
					seen <= 1'b1;
					cnt <= hold_act;
				end
				else if (tick && cnt != '0)
					cnt <= cnt - 7'h01;
			end
			assign held[t] = seen && cnt == '0;
		end
	endgenerate

	logic [1:0] sf_act;
	logic [1:0] sd_act;
	logic wfault;
	logic fault_prev;
	assign sf_act = sf_raw & held;
	assign sd_act = sd_raw & held;
	assign wfault = sf_act[vbtp_pkg::TRAIL_W] | sd_act[vbtp_pkg::TRAIL_W];

	// Local request by priority: lockout, protection fail, forced, fail, degrade, manual
	function automatic vbtp_pkg::vbtp_req_type pick_local(vbtp_pkg::vbtp_ext_type e,
		logic [1:0] sf, logic [1:0] sd, vbtp_pkg::vbtp_rest_type r);
		if (e.cmd == vbtp_pkg::CMD_LOCKOUT)
			return vbtp_pkg::REQ_LO;
		else if (sf[vbtp_pkg::TRAIL_P])
			return vbtp_pkg::REQ_SFP;
		else if (e.cmd == vbtp_pkg::CMD_FORCED)
			return e.trail ? vbtp_pkg::REQ_FSP : vbtp_pkg::REQ_FSW;
		else if (sf[vbtp_pkg::TRAIL_W])
			return vbtp_pkg::REQ_SF;
		else if (sd[vbtp_pkg::TRAIL_W])
			return vbtp_pkg::REQ_SD;
		else if (e.cmd == vbtp_pkg::CMD_MANUAL)
			return e.trail ? vbtp_pkg::REQ_MSP : vbtp_pkg::REQ_MSW;
		else if (r == vbtp_pkg::REST_WTR)
			return vbtp_pkg::REQ_WTR;
		else if (e.cmd == vbtp_pkg::CMD_EXERCISE)
			return vbtp_pkg::REQ_EXERCISE_COMMAND;
		else if (r == vbtp_pkg::REST_DNR)
			return vbtp_pkg::REQ_DNR;
		return vbtp_pkg::REQ_NR;
	endfunction

	// Which trail a request puts on the normal output; exercise keeps the current one
	function automatic logic trail_of(vbtp_pkg::vbtp_req_type q, logic cur);
		unique case (q)
			vbtp_pkg::REQ_MSP, vbtp_pkg::REQ_SD, vbtp_pkg::REQ_SF, vbtp_pkg::REQ_FSP,
			vbtp_pkg::REQ_WTR, vbtp_pkg::REQ_DNR:
				return 1'b1;
			vbtp_pkg::REQ_EXERCISE_COMMAND:
				return cur;
			vbtp_pkg::REQ_NR, vbtp_pkg::REQ_MSW, vbtp_pkg::REQ_FSW, vbtp_pkg::REQ_SFP,
			vbtp_pkg::REQ_LO:
				return 1'b0;
			default:
				return 1'b0;
		endcase
	endfunction

	// Command legality depends on the active operation type
	function automatic logic cmd_ok(vbtp_pkg::vbtp_ext_type e, logic rev);
		unique case (e.cmd)
			vbtp_pkg::CMD_CLEAR, vbtp_pkg::CMD_LOCKOUT:
				return 1'b1;
			vbtp_pkg::CMD_FORCED, vbtp_pkg::CMD_MANUAL:
				return !rev || e.trail;
			vbtp_pkg::CMD_EXERCISE:
				return !rev;
			default:
				return 1'b0;
		endcase
	endfunction

	// Far end request counts only while the protection trail carries a sound APS channel
	vbtp_pkg::vbtp_req_type remote_use;
	assign local_req = pick_local(ext, sf_act, sd_act, rest);
	assign remote_use = sf_raw[vbtp_pkg::TRAIL_P] ? vbtp_pkg::REQ_NR : remote;
	assign eff = remote_use > local_req ? remote_use : local_req;
	assign next_sel = trail_of(eff, sel);

	// Restore state: wait-to-restore after a cleared fault, or do-not-revert
	logic [12:0] wtr_cnt;
	logic clr_now;
	always_comb
	begin
		next_rest = rest;
		if (wfault || ext.cmd inside {vbtp_pkg::CMD_LOCKOUT, vbtp_pkg::CMD_FORCED,
			vbtp_pkg::CMD_MANUAL})
			next_rest = vbtp_pkg::REST_NONE;
		else if (fault_prev && sel)
			next_rest = revert ? vbtp_pkg::REST_WTR : vbtp_pkg::REST_DNR;
		else if (clr_now && sel && !revert)
			next_rest = vbtp_pkg::REST_DNR;
		else if (rest == vbtp_pkg::REST_WTR && wtr_cnt == '0)
			next_rest = vbtp_pkg::REST_NONE;
		else if (rest == vbtp_pkg::REST_DNR && revert)
			next_rest = vbtp_pkg::REST_NONE;
	end

	// Bus write decode
	logic aw_full;
	logic w_full;
	logic [7:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic do_write;
	logic wr_ctrl;
	logic wr_hold;
	logic wr_wtr;
	logic wr_cmd;
	logic wr_istat;
	logic wr_imask;
	vbtp_pkg::vbtp_ext_type new_ext;
	logic cmd_take;
	logic cmd_bad;
	assign do_write = aw_full && w_full && !bvalid;
	assign wr_ctrl = do_write && w_strb[0] && aw_addr == vbtp_pkg::OFS_CTRL;
	assign wr_hold = do_write && w_strb[0] && aw_addr == vbtp_pkg::OFS_HOLD;
	assign wr_wtr = do_write && aw_addr == vbtp_pkg::OFS_WTR;
	assign wr_cmd = do_write && w_strb[0] && aw_addr == vbtp_pkg::OFS_CMD;
	assign wr_istat = do_write && w_strb[0] && aw_addr == vbtp_pkg::OFS_IRQ_STAT;
	assign wr_imask = do_write && w_strb[0] && aw_addr == vbtp_pkg::OFS_IRQ_MASK;
	assign new_ext = vbtp_pkg::vbtp_ext_type'(w_data[vbtp_pkg::CMD_TRAIL:0]);
	assign cmd_take = wr_cmd && cmd_ok(new_ext, revert);
	assign cmd_bad = wr_cmd && !cmd_ok(new_ext, revert);
	assign clr_now = cmd_take && new_ext.cmd == vbtp_pkg::CMD_CLEAR;

	// Protection state, commands and configuration
	always_ff @(posedge ref_clk)
	begin
		if (!reset_n)
		begin
			rest <= vbtp_pkg::REST_NONE;
			sel <= 1'b0;
			fault_prev <= 1'b0;
			ext <= '{trail: 1'b0, cmd: vbtp_pkg::CMD_NONE};
			wtr_cnt <= '0;
			revert_pend <= 1'b1;
			revert <= 1'b1;
			report_en <= 1'b0;
			hold_pend <= vbtp_pkg::HOLD_RESET;
			hold_act <= vbtp_pkg::HOLD_RESET;
			wtr_pend <= vbtp_pkg::WTR_RESET;
			wtr_act <= vbtp_pkg::WTR_RESET;
		end
		else
		begin
			rest <= next_rest;
			sel <= next_sel;
			fault_prev <= wfault;
			if (rest != vbtp_pkg::REST_WTR && next_rest == vbtp_pkg::REST_WTR)
				wtr_cnt <= wtr_act;
			else if (tick && wtr_cnt != '0)
				wtr_cnt <= wtr_cnt - 13'h0001;
			if (clr_now)
				ext <= '{trail: 1'b0, cmd: vbtp_pkg::CMD_NONE};
			else if (cmd_take)
				ext <= new_ext;
			else if (tick && ext.cmd == vbtp_pkg::CMD_EXERCISE)
				ext <= '{trail: 1'b0, cmd: vbtp_pkg::CMD_NONE};
			if (wr_ctrl)
			begin
				revert_pend <= w_data[vbtp_pkg::CTRL_REVERT];
				report_en <= w_data[vbtp_pkg::CTRL_REPORT];
			end
			if (wr_hold)
				hold_pend <= w_data > 32'(vbtp_pkg::HOLD_MAX) ? vbtp_pkg::HOLD_MAX : w_data[6:0];
			if (wr_wtr && w_strb[0])
				wtr_pend[7:0] <= w_data[7:0];
			if (wr_wtr && w_strb[1])
				wtr_pend[12:8] <= w_data[12:8];
			// Copied only with no switch active or asked, so traffic is never disturbed
			if (eff == vbtp_pkg::REQ_NR && !sel)
			begin
				revert <= revert_pend;
				hold_act <= hold_pend;
				wtr_act <= wtr_pend;
			end
		end
	end

	// Received APS: three equal frames in a row before a new request is believed
	logic [2:0] aps_shift;
	logic [3:0] aps_cand;
	logic [1:0] aps_cnt;
	logic [3:0] aps_frame;
	logic aps_done;
	logic remote_new;
	assign aps_frame = {aps_shift, p_st.d};
	assign aps_done = p_rise && p_hit && p_pos == vbtp_pkg::APS_LAST;
	assign remote_new = aps_done && aps_frame == aps_cand && aps_cnt == vbtp_pkg::PERSIST_LAST
		&& aps_frame != remote;
	always_ff @(posedge ref_clk)
	begin
		if (!reset_n)
		begin
			aps_shift <= '0;
			aps_cand <= '0;
			aps_cnt <= '0;
			remote <= vbtp_pkg::REQ_NR;
		end
		else
		begin
			if (p_rise && p_hit)
				aps_shift <= aps_frame[2:0];
			if (aps_done && aps_frame != aps_cand)
			begin
				aps_cand <= aps_frame;
				aps_cnt <= vbtp_pkg::PERSIST_FIRST;
			end
			else if (aps_done && aps_cnt != vbtp_pkg::PERSIST_LAST)
				aps_cnt <= aps_cnt + 2'h1;
			if (remote_new)
				remote <= vbtp_pkg::vbtp_req_type'(aps_frame);
		end
	end

	// Stream outputs: selector on the sink side, bridge and APS insertion on the source side
	logic sel_fail;
	assign sel_fail = sel ? sf_raw[vbtp_pkg::TRAIL_P] : sf_raw[vbtp_pkg::TRAIL_W];
	always_ff @(posedge ref_clk)
	begin
		if (!reset_n)
		begin
			n_ai_out <= '0;
			trail_fail_action <= 1'b0;
			reported_server_fail <= 1'b0;
			w_ai_out <= '0;
			p_ai_out <= '0;
			aps_tx <= '0;
		end
		else
		begin
			n_ai_out <= sel ? p_st : w_st;
			trail_fail_action <= sel_fail;
			reported_server_fail <= sel_fail && report_en;
			w_ai_out <= n_st;
			aps_tx <= local_req;
			p_ai_out.ck <= n_st.ck;
			p_ai_out.fs <= n_st.fs;
			p_ai_out.d <= n_hit ? aps_tx[2'(vbtp_pkg::APS_LAST - n_pos)] : n_st.d;
		end
	end

	// Interrupts: sticky, write one to clear, an event in the clearing cycle wins
	logic [3:0] irq_stat;
	logic [3:0] irq_mask;
	logic [3:0] irq_ev;
	logic [3:0] irq_clr;
	assign irq_ev[vbtp_pkg::IRQ_SWITCH] = next_sel != sel;
	assign irq_ev[vbtp_pkg::IRQ_REJECT] = cmd_bad;
	assign irq_ev[vbtp_pkg::IRQ_REMOTE] = remote_new;
	assign irq_ev[vbtp_pkg::IRQ_FAIL] = sel_fail && report_en && !reported_server_fail;
	assign irq_clr = wr_istat ? w_data[3:0] : 4'h0;
	always_ff @(posedge ref_clk)
	begin
		if (!reset_n)
		begin
			irq_stat <= '0;
			irq_mask <= '0;
			irq <= 1'b0;
		end
		else
		begin
			irq_stat <= (irq_stat & ~irq_clr) | irq_ev;
			if (wr_imask)
				irq_mask <= w_data[3:0];
			irq <= |(irq_stat & irq_mask);
		end
	end

	// AXI4-Lite channels: address and data taken in either order, response after both
	function automatic logic mapped(logic [7:0] a);
		return a inside {vbtp_pkg::OFS_CTRL, vbtp_pkg::OFS_HOLD, vbtp_pkg::OFS_WTR,
			vbtp_pkg::OFS_CMD, vbtp_pkg::OFS_STAT, vbtp_pkg::OFS_IRQ_STAT, vbtp_pkg::OFS_IRQ_MASK};
	endfunction
	logic next_aw_full;
	logic next_w_full;
	logic next_rvalid;
	assign next_aw_full = (aw_full && !do_write) || (awvalid && awready);
	assign next_w_full = (w_full && !do_write) || (wvalid && wready);
	assign next_rvalid = (rvalid && !rready) || (arvalid && arready);
	always_ff @(posedge ref_clk)
	begin
		if (!reset_n)
		begin
			aw_full <= 1'b0;
			w_full <= 1'b0;
			awready <= 1'b0;
			wready <= 1'b0;
			aw_addr <= '0;
			w_data <= '0;
			w_strb <= '0;
			bvalid <= 1'b0;
			bresp <= vbtp_pkg::RESP_OKAY;
		end
		else
		begin
			aw_full <= next_aw_full;
			w_full <= next_w_full;
			awready <= !next_aw_full;
			wready <= !next_w_full;
			if (awvalid && awready)
				aw_addr <= awaddr;
			if (wvalid && wready)
			begin
				w_data <= wdata;
				w_strb <= wstrb;
			end
			if (do_write)
			begin
				bvalid <= 1'b1;
				bresp <= mapped(aw_addr) ? vbtp_pkg::RESP_OKAY : vbtp_pkg::RESP_SLVERR;
			end
			else if (bready)
				bvalid <= 1'b0;
		end
	end

	// Read mux; the status word shows the live protection state
	vbtp_pkg::vbtp_status_type status;
	logic [31:0] rd_word;
	assign status = '{remote: remote, local_req: local_req, eff: eff, rest: rest,
		fail: trail_fail_action, sel: sel};
	always_comb
	begin
		rd_word = '0;
		unique case (araddr)
			vbtp_pkg::OFS_CTRL:
				rd_word = {30'h00000000, report_en, revert_pend};
			vbtp_pkg::OFS_HOLD:
				rd_word = {25'h0000000, hold_pend};
			vbtp_pkg::OFS_WTR:
				rd_word = {19'h00000, wtr_pend};
			vbtp_pkg::OFS_CMD:
				rd_word = {28'h0000000, ext};
			vbtp_pkg::OFS_STAT:
				rd_word = {16'h0000, status};
			vbtp_pkg::OFS_IRQ_STAT:
				rd_word = {28'h0000000, irq_stat};
			vbtp_pkg::OFS_IRQ_MASK:
				rd_word = {28'h0000000, irq_mask};
			default:
				rd_word = '0;
		endcase
	end
	always_ff @(posedge ref_clk)
	begin
		if (!reset_n)
		begin
			arready <= 1'b0;
			rvalid <= 1'b0;
			rdata <= '0;
			rresp <= vbtp_pkg::RESP_OKAY;
		end
		else
		begin
			arready <= !next_rvalid;
			rvalid <= next_rvalid;
			if (arvalid && arready)
			begin
				rdata <= rd_word;
				rresp <= mapped(araddr) ? vbtp_pkg::RESP_OKAY : vbtp_pkg::RESP_SLVERR;
			end
		end
	end
endmodule

// ===== design/vbtp_pkg.sv
// Package: constants, register map and types of the VC-11 bi-directional trail protection block
package vbtp_pkg;
	// Timing
	localparam int CLK_HZ = 200000000;
	localparam int TICK_MS = 100;
	localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
	localparam int SWITCH_MS = 50;
	localparam int TICK_W = 25;
	// Stream framing: bit index within the multiframe
	localparam int IDX_W = 10;
	localparam logic [9:0] K4_FIRST = 10'h010;
	localparam logic [1:0] APS_LAST = 2'h3;
	localparam logic [1:0] PERSIST_LAST = 2'h2;
	localparam logic [1:0] PERSIST_FIRST = 2'h1;
	// Configuration ranges and reset values (hold-off and restore in 100 ms ticks)
	localparam logic [6:0] HOLD_MAX = 7'h64;
	localparam logic [6:0] HOLD_RESET = 7'h00;
	localparam logic [12:0] WTR_RESET = 13'h0BB8;
	// Register map
	localparam int ADDR_W = 8;
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_HOLD = 8'h04;
	localparam logic [7:0] OFS_WTR = 8'h08;
	localparam logic [7:0] OFS_CMD = 8'h0C;
	localparam logic [7:0] OFS_STAT = 8'h10;
	localparam logic [7:0] OFS_IRQ_STAT = 8'h14;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h18;
	localparam int CTRL_REVERT = 0;
	localparam int CTRL_REPORT = 1;
	localparam int CMD_TRAIL = 3;
	// Interrupt status bits
	localparam int IRQ_W = 4;
	localparam int IRQ_SWITCH = 0;
	localparam int IRQ_REJECT = 1;
	localparam int IRQ_REMOTE = 2;
	localparam int IRQ_FAIL = 3;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// Fail pair as carried by the access points
	localparam int FAIL_SF = 1;
	localparam int FAIL_SD = 0;
	localparam int TRAIL_W = 0;
	localparam int TRAIL_P = 1;

	typedef struct packed {
		logic d;
		logic ck;
		logic fs;
	} vbtp_stream_type;

	typedef enum logic [2:0] {CMD_NONE, CMD_CLEAR, CMD_LOCKOUT, CMD_FORCED, CMD_MANUAL,
		CMD_EXERCISE} vbtp_cmd_type;

	// Requests in ascending priority; the code is what travels in the APS bits
	typedef enum logic [3:0] {REQ_NR, REQ_DNR, REQ_EXERCISE_COMMAND, REQ_WTR, REQ_MSW, REQ_MSP, REQ_SD,
		REQ_SF, REQ_FSW, REQ_FSP, REQ_SFP, REQ_LO} vbtp_req_type;

	typedef enum logic [1:0] {REST_NONE, REST_DNR, REST_WTR} vbtp_rest_type;

	typedef struct packed {
		logic trail;
		vbtp_cmd_type cmd;
	} vbtp_ext_type;

	typedef struct packed {
		logic [3:0] remote;
		logic [3:0] local_req;
		logic [3:0] eff;
		vbtp_rest_type rest;
		logic fail;
		logic sel;
	} vbtp_status_type;
endpackage

// ===== design/vbtp_link_port.sv
// Synchroniser, clock edge finder and frame bit counter for one connection point
`timescale 1ns/1ps
module vbtp_link_port (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire vbtp_pkg::vbtp_stream_type pin_stream,
	input wire logic [1:0] pin_fail,
	output vbtp_pkg::vbtp_stream_type stream,
	output logic [1:0] fail,
	output logic rise,
	output logic aps_hit,
	output logic [1:0] aps_pos
);
	logic [4:0] meta;
	logic [4:0] sync;
	logic ck_prev;
	logic [9:0] idx;
	logic [9:0] next_idx;
	logic [9:0] rel;

	// Two stages on every pin; only the second stage is looked at
	always_ff @(posedge ref_clk)
	begin
		if (!reset_n)
		begin
			meta <= '0;
			sync <= '0;
			ck_prev <= 1'b0;
			idx <= '0;
		end
		else
		begin
			meta <= {pin_stream, pin_fail};
			sync <= meta;
			ck_prev <= stream.ck;
			idx <= next_idx;
		end
	end

	// Bit index restarts at frame start, moves on each link clock rise
	assign stream = vbtp_pkg::vbtp_stream_type'(sync[4:2]);
	assign fail = sync[1:0];
	assign rise = stream.ck & ~ck_prev;
	assign next_idx = !rise ? idx : (stream.fs ? '0 : idx + 10'h001);
	assign rel = next_idx - vbtp_pkg::K4_FIRST;
	assign aps_hit = rel <= {8'h00, vbtp_pkg::APS_LAST};
	assign aps_pos = rel[1:0];
endmodule

// ===== bench/vbtp_core_assertions.sv
// Checker of the protection core port behaviour
`timescale 1ns/1ps
module vbtp_core_assertions (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic awvalid,
	input wire logic awready,
	input wire logic wvalid,
	input wire logic wready,
	input wire logic [1:0] bresp,
	input wire logic bvalid,
	input wire logic bready,
	input wire logic [31:0] rdata,
	input wire logic rvalid,
	input wire logic rready,
	input wire vbtp_pkg::vbtp_stream_type w_ai_in,
	input wire logic [1:0] w_ai_fail,
	input wire vbtp_pkg::vbtp_stream_type p_ai_in,
	input wire logic [1:0] p_ai_fail,
	input wire vbtp_pkg::vbtp_stream_type n_ci_in,
	input wire vbtp_pkg::vbtp_stream_type n_ai_out,
	input wire logic trail_fail_action,
	input wire logic reported_server_fail,
	input wire vbtp_pkg::vbtp_stream_type w_ai_out,
	input wire vbtp_pkg::vbtp_stream_type p_ai_out
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!reset_n);
	logic [2:0] up;
	// Pipeline warm-up, since outputs only mirror pins once the sync stages refill
	always_ff @(posedge ref_clk)
	begin
		if (!reset_n)
			up <= 3'h0;
		else if (up != 3'h5)
			up <= up + 3'h1;
	end
	wire ok = (up == 3'h5);
	property p_bridge;
		ok |-> w_ai_out == $past(n_ci_in, 3);
	endproperty
	a_bridge: assert property (p_bridge) else $error("bridge copy wrong");
	property p_prot_frame;
		ok |-> p_ai_out.ck == $past(n_ci_in.ck, 3) && p_ai_out.fs == $past(n_ci_in.fs, 3);
	endproperty
	a_prot_frame: assert property (p_prot_frame) else $error("protection framing wrong");
	property p_norm_out;
		ok |-> n_ai_out == $past(w_ai_in, 3) || n_ai_out == $past(p_ai_in, 3);
	endproperty
	a_norm_out: assert property (p_norm_out) else $error("normal output from no trail");
	property p_tsf;
		ok |-> trail_fail_action == $past(w_ai_fail[1], 3)
			|| trail_fail_action == $past(p_ai_fail[1], 3);
	endproperty
	a_tsf: assert property (p_tsf) else $error("trail fail not from a trail");
	property p_report;
		reported_server_fail |-> trail_fail_action;
	endproperty
	a_report: assert property (p_report) else $error("report without fail");
	property p_bhold;
		bvalid && !bready |=> bvalid && $stable(bresp);
	endproperty
	a_bhold: assert property (p_bhold) else $error("write answer dropped");
	property p_rhold;
		rvalid && !rready |=> rvalid && $stable(rdata);
	endproperty
	a_rhold: assert property (p_rhold) else $error("read answer dropped");
	property p_wresp;
		awvalid && awready && wvalid && wready |=> !awready && !wready ##1 bvalid;
	endproperty
	a_wresp: assert property (p_wresp) else $error("write answer late");
endmodule

// ===== bench/vbtp_far_end.sv
// Adjacent trail function model: one framed link stream with APS in K4 slots
`timescale 1ns/1ps
module vbtp_far_end #(
	parameter int FRAME_BITS = 32
) (
	input wire logic [3:0] aps,
	output vbtp_pkg::vbtp_stream_type s
);
	logic [5:0] idx = 6'h00;
	initial s = '0;
	// Data moves on the falling edge; the rise is kept off the sampling edges
	always
	begin
		#61 s.ck = 1'b1;
		#64 s.ck = 1'b0;
		idx = (idx == 6'(FRAME_BITS - 1)) ? 6'h00 : idx + 6'h01;
		s.fs = (idx == 6'h00);
		s.d = (idx >= 6'h10 && idx < 6'h14) ? aps[6'h13 - idx] : ^idx[2:0];
	end
endmodule

// ===== bench/vc11_bidir_trail_protection_bench.sv
// Self-checking bench of the trail protection core
`timescale 1ns/1ps
module vc11_bidir_trail_protection_bench;
	logic ref_clk = 1'b0;
	logic reset_n = 1'b0;
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'hF;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, irq, tfa, rsf;
	logic [31:0] rdata;
	logic [1:0] bresp, rresp;
	logic [1:0] w_fail = 2'h0;
	logic [1:0] p_fail = 2'h0;
	vbtp_pkg::vbtp_stream_type w_in, p_in, n_in, n_out, w_out, p_out;
	int n_mismatch = 0;
	int checks = 0;
	always #2.5 ref_clk = ~ref_clk;
	vbtp_far_end i_w (.aps(4'h9), .s(w_in));
	vbtp_far_end i_p (.aps(4'h0), .s(p_in));
	vbtp_far_end i_n (.aps(4'h5), .s(n_in));
	vbtp_core #(.TICK_CYCLES(16)) i_dut (.ref_clk(ref_clk), .reset_n(reset_n),
		.awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
		.wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
		.bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .irq(irq),
		.w_ai_in(w_in), .w_ai_fail(w_fail), .p_ai_in(p_in), .p_ai_fail(p_fail),
		.n_ci_in(n_in), .n_ai_out(n_out), .trail_fail_action(tfa),
		.reported_server_fail(rsf), .w_ai_out(w_out), .p_ai_out(p_out));
	task automatic stop_test;
		$display("checks %0d n_mismatch %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("Error %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Write cycle: both channels offered together, each dropped once taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		int n;
		@(posedge ref_clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (n = 0; n < 50 && !bvalid; n++)
		begin
			@(posedge ref_clk);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
		end
		bready <= 1'b0;
		if (n == 50)
			stop_fail();
		chk(32'(bresp), 32'(er));
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		@(posedge ref_clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n < 50 && !rvalid; n++)
		begin
			@(posedge ref_clk);
			if (arready)
				arvalid <= 1'b0;
		end
		rready <= 1'b0;
		d = rdata;
		r = rresp;
		if (n == 50)
			stop_fail();
	endtask
	task automatic stop_fail;
		n_mismatch++;
		stop_test();
	endtask
	// Poll status until masked bits match, bounded
	task automatic wait_stat(input logic [31:0] m, input logic [31:0] v);
		logic [31:0] d;
		logic [1:0] r;
		for (int n = 0; n < 100; n++)
		begin
			rd(vbtp_pkg::OFS_STAT, d, r);
			if ((d & m) == v)
				break;
		end
		chk(d & m, v);
	endtask
	task automatic t_regs;
		logic [31:0] d;
		logic [1:0] r;
		rd(vbtp_pkg::OFS_CTRL, d, r);
		chk(d, 32'h1);
		rd(vbtp_pkg::OFS_WTR, d, r);
		chk(d, 32'(vbtp_pkg::WTR_RESET));
		rd(8'h40, d, r);
		chk(32'(r), 32'(vbtp_pkg::RESP_SLVERR));
		wr(8'h40, 32'h1, vbtp_pkg::RESP_SLVERR);
		wr(vbtp_pkg::OFS_HOLD, 32'h0, vbtp_pkg::RESP_OKAY);
	endtask
	// Commands in revertive mode: forced, lockout, manual, clear; exercise refused
	task automatic t_cmds;
		logic [31:0] cmd [5] = '{32'hB, 32'h2, 32'hC, 32'h2, 32'h1};
		logic [31:0] sel [5] = '{32'h1, 32'h0, 32'h1, 32'h0, 32'h0};
		logic [31:0] d;
		logic [1:0] r;
		for (int i = 0; i < 5; i++)
		begin
			wr(vbtp_pkg::OFS_CMD, cmd[i], vbtp_pkg::RESP_OKAY);
			wait_stat(32'h1, sel[i]);
		end
		wr(vbtp_pkg::OFS_CMD, 32'h5, vbtp_pkg::RESP_OKAY);
		rd(vbtp_pkg::OFS_IRQ_STAT, d, r);
		chk(d & 32'h2, 32'h2);
	endtask
	// Masked, unmasked, cleared, then raised by a working trail fail
	task automatic t_switch;
		chk(32'(irq), 32'h0);
		wr(vbtp_pkg::OFS_IRQ_MASK, 32'h1, vbtp_pkg::RESP_OKAY);
		repeat (2) @(posedge ref_clk);
		chk(32'(irq), 32'h1);
		wr(vbtp_pkg::OFS_IRQ_STAT, 32'hF, vbtp_pkg::RESP_OKAY);
		repeat (2) @(posedge ref_clk);
		chk(32'(irq), 32'h0);
		w_fail <= 2'h2;
		wait_stat(32'h1, 32'h1);
		chk(32'(irq), 32'h1);
		chk(32'(tfa), 32'h0);
	endtask
	// Both trails failed: fail reported only while enabled
	task automatic t_report;
		p_fail <= 2'h2;
		repeat (20) @(posedge ref_clk);
		chk(32'(tfa), 32'h1);
		chk(32'(rsf), 32'h0);
		wr(vbtp_pkg::OFS_CTRL, 32'h3, vbtp_pkg::RESP_OKAY);
		repeat (3) @(posedge ref_clk);
		chk(32'(rsf), 32'h1);
		wr(vbtp_pkg::OFS_CTRL, 32'h1, vbtp_pkg::RESP_OKAY);
		repeat (3) @(posedge ref_clk);
		chk(32'(rsf), 32'h0);
	endtask
	// Non-revertive once both fails clear: manual to working is taken, not refused
	task automatic t_nonrev;
		logic [31:0] d;
		logic [1:0] r;
		w_fail <= 2'h0;
		p_fail <= 2'h0;
		wr(vbtp_pkg::OFS_CTRL, 32'h0, vbtp_pkg::RESP_OKAY);
		wr(vbtp_pkg::OFS_IRQ_STAT, 32'hF, vbtp_pkg::RESP_OKAY);
		wr(vbtp_pkg::OFS_CMD, 32'h4, vbtp_pkg::RESP_OKAY);
		wait_stat(32'hF01, 32'h400);
		rd(vbtp_pkg::OFS_IRQ_STAT, d, r);
		chk(d & 32'h2, 32'h0);
	endtask
	initial
	begin
		repeat (5) @(posedge ref_clk);
		reset_n <= 1'b1;
		repeat (2) @(posedge ref_clk);
		t_regs();
		t_cmds();
		t_switch();
		t_report();
		t_nonrev();
		stop_test();
	end
endmodule
bind vbtp_core vbtp_core_assertions i_chk (.ref_clk(ref_clk), .reset_n(reset_n),
	.awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready),
	.bresp(bresp), .bvalid(bvalid), .bready(bready), .rdata(rdata), .rvalid(rvalid),
	.rready(rready), .w_ai_in(w_ai_in), .w_ai_fail(w_ai_fail), .p_ai_in(p_ai_in),
	.p_ai_fail(p_ai_fail), .n_ci_in(n_ci_in), .n_ai_out(n_ai_out),
	.trail_fail_action(trail_fail_action), .reported_server_fail(reported_server_fail),
	.w_ai_out(w_ai_out), .p_ai_out(p_ai_out));
